// ==== btcr_pkg.sv ====
// constants and carrier types of the bridge timeout and capability register bank
package btcr_pkg;

  localparam int ADDR_W = 8;
  localparam int TMO_W = 16;

  // register byte offsets
  localparam logic [7:0] OFS_MASTER_TIMEOUT = 8'h80;
  localparam logic [7:0] OFS_SLOT_ID = 8'hB0;
  localparam logic [7:0] OFS_POWER_CAP = 8'hDC;
  localparam logic [7:0] OFS_TIMEOUT_STATUS = 8'hF0;

  // field positions
  localparam int PRI_TMO_LSB = 0;
  localparam int SEC_TMO_LSB = 16;
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_LINK_LSB = 8;
  localparam int SLOT_NUM_LSB = 16;
  localparam int FIRST_IN_CHASSIS_BIT = 21;
  localparam int CHASSIS_LSB = 24;
  localparam int PM_REV_LSB = 16;
  localparam int STAT_PRI_BIT = 0;
  localparam int STAT_SEC_BIT = 1;

  // reset values and fixed codes
  localparam logic [15:0] MASTER_TIMEOUT_RST = 16'h8000;
  localparam logic [4:0] SLOT_NUM_RST = 5'h00;
  localparam logic FIRST_IN_CHASSIS_RST = 1'b0;
  localparam logic [7:0] CHASSIS_RST = 8'h00;
  localparam logic [7:0] CAP_ID_POWER = 8'h01;
  localparam logic [7:0] CAP_ID_SLOT = 8'h04;
  localparam logic [7:0] HOT_SWAP_CAPABILITY_CODE = 8'h06;
  localparam logic [7:0] SLOT_NEXT_END = 8'h00;
  localparam logic [7:0] POWER_NEXT_LINK = 8'h0B;
  localparam logic [2:0] PM_REVISION = 3'h1;

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } btcr_req_t;

  // per-port delayed transaction wait levels
  typedef struct packed {
    logic pri_wait;
    logic sec_wait;
  } btcr_wait_t;

  // whole state of the register bank
  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic [TMO_W-1:0] pri_limit;
    logic [TMO_W-1:0] sec_limit;
    logic [TMO_W-1:0] pri_cnt;
    logic [TMO_W-1:0] sec_cnt;
    logic pri_tmo;
    logic sec_tmo;
    logic [1:0] tmo_status;
    logic [4:0] slot_num;
    logic first_in_chassis;
    logic [7:0] chassis;
    logic strap_done;
    logic mode_strap_low;
    logic mode_strap_high;
  } btcr_state_t;

endpackage : btcr_pkg

// ==== btcr_regs.sv ====
// bridge master timeout counters and capability registers behind an avalon-mm slave
// What this block does
// R1: primary master timeout limit, bits 15:0, read-write, resets to 8000h.
// R2: secondary master timeout limit, bits 31:16, read-write, resets to 8000h.
// R3: count clocks while delayed completion waits; pulse timeout on reaching limit.
// R4: slot capability identifier is read-only 04h.
// R5: slot next link reads 00h when low strap set, or low clear and high set.
// R6: five-bit expansion slot number, read-write, resets to zero.
// R7: first-in-chassis flag, read-write, resets to zero.
// R8: bits 23:22 of slot dword read zero and reset to zero.
// R9: eight-bit chassis number in top byte, read-write, resets to zero.
// R10: power capability identifier reads fixed 01h.
// R11: power capability next link reads fixed 0Bh.
// R12: power management revision reads 001.
// R13: clock, auxiliary power and device init bits read zero.
// R14: D1 and D2 support bits read zero.
// R15: wake support field and bits 24:22 read zero.
// R16: writes to read-only or reserved fields complete and change nothing.
//
// The implementer's own choice: the Avalon-MM register port.
module btcr_regs #(
  parameter logic [7:0] SLOT_NEXT_ALT = 8'hDC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire btcr_pkg::btcr_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire btcr_pkg::btcr_wait_t dly_wait,
  input wire logic mode_strap_low,
  input wire logic mode_strap_high,
  output logic pri_timeout,
  output logic sec_timeout
);

  btcr_pkg::btcr_state_t st;
  btcr_pkg::btcr_state_t next_st;

  // every access takes one wait state: the request is seen with waitrequest high,
  // the answer stands for one cycle with waitrequest low, and a write lands on that edge.
  // straps are caught once after reset so that a strap moving later cannot change the link.
  // a timeout counter stalls at its limit until its wait level drops, so each wait
  // gives at most one pulse; a limit of zero never fires.

  // merge write data into a dword under the byte enables
  function automatic logic [31:0] btcr_merge(
    input logic [31:0] old_v,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return r;
  endfunction : btcr_merge

  // one step of a master timeout counter: {hit, next count}
  function automatic logic [btcr_pkg::TMO_W:0] btcr_tick(
    input logic waiting,
    input logic [btcr_pkg::TMO_W-1:0] cnt,
    input logic [btcr_pkg::TMO_W-1:0] lim
  );
    logic [btcr_pkg::TMO_W-1:0] n;
    n = cnt + 1'b1;
    if (!waiting) begin
      return '0;
    end else if (cnt == lim) begin
      return {1'b0, cnt};
    end else begin
      return {n == lim, n};
    end
  endfunction : btcr_tick

  // a read or write request is present
  function automatic logic btcr_is_request(
    input btcr_pkg::btcr_req_t req
  );
    return req.read || req.write;
  endfunction : btcr_is_request

  // a write commits on the edge where waitrequest stands low
  function automatic logic btcr_write_commit(
    input btcr_pkg::btcr_req_t req,
    input logic waitrequest
  );
    return req.write && !req.read && !waitrequest;
  endfunction : btcr_write_commit

  // slot next link: end of list unless both straps are clear
  function automatic logic [7:0] btcr_slot_next(
    input logic strap_low,
    input logic strap_high,
    input logic [7:0] alt_next
  );
    logic [7:0] nxt;
    nxt = alt_next;
    if (strap_low) begin
      nxt = btcr_pkg::SLOT_NEXT_END; // R5
    end else if (strap_high) begin
      nxt = btcr_pkg::SLOT_NEXT_END; // R5
    end
    return nxt;
  endfunction : btcr_slot_next

  // master timeout dword: primary low half, secondary high half
  function automatic logic [31:0] btcr_timeout_dword(
    input btcr_pkg::btcr_state_t s
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    r[btcr_pkg::PRI_TMO_LSB +: btcr_pkg::TMO_W] = s.pri_limit; // R1
    r[btcr_pkg::SEC_TMO_LSB +: btcr_pkg::TMO_W] = s.sec_limit; // R2
    return r;
  endfunction : btcr_timeout_dword

  // slot identification dword; reserved bits 23:22 stay zero
  function automatic logic [31:0] btcr_slot_dword(
    input btcr_pkg::btcr_state_t s,
    input logic [7:0] nxt
  );
    logic [31:0] r;
    r = 32'h0000_0000; // R8
    r[btcr_pkg::CAP_ID_LSB +: 8] = btcr_pkg::CAP_ID_SLOT; // R4
    r[btcr_pkg::NEXT_LINK_LSB +: 8] = nxt; // R5
    r[btcr_pkg::SLOT_NUM_LSB +: 5] = s.slot_num; // R6
    r[btcr_pkg::FIRST_IN_CHASSIS_BIT] = s.first_in_chassis; // R7
    r[btcr_pkg::CHASSIS_LSB +: 8] = s.chassis; // R9
    return r;
  endfunction : btcr_slot_dword

  // power capability header; clock, aux, init, D1, D2, wake and reserved bits read zero
  function automatic logic [31:0] btcr_power_dword();
    logic [31:0] r;
    r = 32'h0000_0000; // R13 R14 R15
    r[btcr_pkg::CAP_ID_LSB +: 8] = btcr_pkg::CAP_ID_POWER; // R10
    r[btcr_pkg::NEXT_LINK_LSB +: 8] = btcr_pkg::POWER_NEXT_LINK; // R11
    r[btcr_pkg::PM_REV_LSB +: 3] = btcr_pkg::PM_REVISION; // R12
    return r;
  endfunction : btcr_power_dword

  // sticky timeout status dword
  function automatic logic [31:0] btcr_status_dword(
    input btcr_pkg::btcr_state_t s
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    r[btcr_pkg::STAT_PRI_BIT] = s.tmo_status[btcr_pkg::STAT_PRI_BIT];
    r[btcr_pkg::STAT_SEC_BIT] = s.tmo_status[btcr_pkg::STAT_SEC_BIT];
    return r;
  endfunction : btcr_status_dword

  // read value of each dword; unmapped offsets read zero
  function automatic logic [31:0] btcr_read(
    input btcr_pkg::btcr_state_t s,
    input logic [btcr_pkg::ADDR_W-1:0] addr,
    input logic [7:0] alt_next
  );
    logic [31:0] r;
    logic [7:0] nxt;
    r = 32'h0000_0000;
    nxt = btcr_slot_next(s.mode_strap_low, s.mode_strap_high, alt_next); // R5
    case (addr)
      btcr_pkg::OFS_MASTER_TIMEOUT: begin
        r = btcr_timeout_dword(s);
      end
      btcr_pkg::OFS_SLOT_ID: begin
        r = btcr_slot_dword(s, nxt);
      end
      btcr_pkg::OFS_POWER_CAP: begin
        r = btcr_power_dword();
      end
      btcr_pkg::OFS_TIMEOUT_STATUS: begin
        r = btcr_status_dword(s);
      end
      default: begin
        r = 32'h0000_0000; // R16
      end
    endcase
    return r;
  endfunction : btcr_read

  // take the request while waitrequest is high, answer the cycle after
  function automatic btcr_pkg::btcr_state_t btcr_answer(
    input btcr_pkg::btcr_state_t s,
    input btcr_pkg::btcr_req_t req,
    input logic [7:0] alt_next
  );
    btcr_pkg::btcr_state_t n;
    n = s;
    if (btcr_is_request(req) && s.waitrequest) begin
      n.waitrequest = 1'b0;
      n.readdata = btcr_read(s, req.address, alt_next);
    end else begin
      n.waitrequest = 1'b1;
    end
    return n;
  endfunction : btcr_answer

  // sticky status: a new timeout sets its bit even while software clears it
  function automatic logic [1:0] btcr_status_next(
    input logic [1:0] old_v,
    input logic [1:0] clr,
    input logic set_pri,
    input logic set_sec
  );
    logic [1:0] r;
    r = old_v & ~clr;
    if (set_pri) begin
      r[btcr_pkg::STAT_PRI_BIT] = 1'b1;
    end
    if (set_sec) begin
      r[btcr_pkg::STAT_SEC_BIT] = 1'b1;
    end
    return r;
  endfunction : btcr_status_next

  // straps are latched once, at the first edge after reset release
  function automatic btcr_pkg::btcr_state_t btcr_strap_capture(
    input btcr_pkg::btcr_state_t s,
    input logic strap_low,
    input logic strap_high
  );
    btcr_pkg::btcr_state_t n;
    n = s;
    if (!s.strap_done) begin
      n.strap_done = 1'b1;
      n.mode_strap_low = strap_low;
      n.mode_strap_high = strap_high;
    end
    return n;
  endfunction : btcr_strap_capture

  // timeout limits under the byte enables
  function automatic btcr_pkg::btcr_state_t btcr_write_timeout(
    input btcr_pkg::btcr_state_t s,
    input btcr_pkg::btcr_req_t req
  );
    btcr_pkg::btcr_state_t n;
    logic [31:0] v;
    n = s;
    v = btcr_merge(btcr_timeout_dword(s), req.writedata, req.byteenable);
    n.pri_limit = v[btcr_pkg::PRI_TMO_LSB +: btcr_pkg::TMO_W]; // R1
    n.sec_limit = v[btcr_pkg::SEC_TMO_LSB +: btcr_pkg::TMO_W]; // R2
    return n;
  endfunction : btcr_write_timeout

  // slot dword write: only slot number, first-in-chassis and chassis are kept
  function automatic btcr_pkg::btcr_state_t btcr_write_slot(
    input btcr_pkg::btcr_state_t s,
    input btcr_pkg::btcr_req_t req
  );
    btcr_pkg::btcr_state_t n;
    logic [31:0] v;
    n = s;
    v = btcr_merge(btcr_slot_dword(s, btcr_pkg::SLOT_NEXT_END), req.writedata, req.byteenable);
    n.slot_num = v[btcr_pkg::SLOT_NUM_LSB +: 5]; // R6
    n.first_in_chassis = v[btcr_pkg::FIRST_IN_CHASSIS_BIT]; // R7
    n.chassis = v[btcr_pkg::CHASSIS_LSB +: 8]; // R9
    return n;
  endfunction : btcr_write_slot

  // state loaded by reset
  function automatic btcr_pkg::btcr_state_t btcr_reset_state();
    btcr_pkg::btcr_state_t s;
    s = '0;
    s.waitrequest = 1'b1;
    s.readdata = 32'h0000_0000;
    s.pri_limit = btcr_pkg::MASTER_TIMEOUT_RST; // R1
    s.sec_limit = btcr_pkg::MASTER_TIMEOUT_RST; // R2
    s.pri_cnt = '0;
    s.sec_cnt = '0;
    s.pri_tmo = 1'b0;
    s.sec_tmo = 1'b0;
    s.tmo_status = 2'b00;
    s.slot_num = btcr_pkg::SLOT_NUM_RST; // R6
    s.first_in_chassis = btcr_pkg::FIRST_IN_CHASSIS_RST; // R7
    s.chassis = btcr_pkg::CHASSIS_RST; // R9
    s.strap_done = 1'b0;
    s.mode_strap_low = 1'b0;
    s.mode_strap_high = 1'b0;
    return s;
  endfunction : btcr_reset_state

  logic [btcr_pkg::TMO_W:0] pri_step;
  logic [btcr_pkg::TMO_W:0] sec_step;
  logic [1:0] clr_v;
  logic wr_go;

  always_comb begin
    next_st = st;
    pri_step = btcr_tick(dly_wait.pri_wait, st.pri_cnt, st.pri_limit); // R3
    sec_step = btcr_tick(dly_wait.sec_wait, st.sec_cnt, st.sec_limit); // R3
    wr_go = btcr_write_commit(avs_req, st.waitrequest);
    clr_v = 2'b00;

    // strap levels are caught once, on the first edge after reset release
    next_st = btcr_strap_capture(next_st, mode_strap_low, mode_strap_high); // R5

    // timeout counters and their one-cycle event pulses
    next_st.pri_cnt = pri_step[btcr_pkg::TMO_W-1:0]; // R3
    next_st.sec_cnt = sec_step[btcr_pkg::TMO_W-1:0]; // R3
    next_st.pri_tmo = pri_step[btcr_pkg::TMO_W]; // R3
    next_st.sec_tmo = sec_step[btcr_pkg::TMO_W]; // R3

    // one wait state: answer on the cycle after the request is seen
    next_st = btcr_answer(next_st, avs_req, SLOT_NEXT_ALT);

    if (wr_go) begin
      case (avs_req.address)
        btcr_pkg::OFS_MASTER_TIMEOUT: begin
          next_st = btcr_write_timeout(next_st, avs_req); // R1 R2
        end
        btcr_pkg::OFS_SLOT_ID: begin
          next_st = btcr_write_slot(next_st, avs_req); // R16
        end
        btcr_pkg::OFS_TIMEOUT_STATUS: begin
          // write one to clear
          if (avs_req.byteenable[0]) begin
            clr_v = avs_req.writedata[1:0];
          end
        end
        default: begin
          // power capability and unmapped offsets ignore writes
        end
      endcase
    end

    // a new timeout sets its sticky bit even during a clear
    next_st.tmo_status = btcr_status_next(st.tmo_status, clr_v,
                                          pri_step[btcr_pkg::TMO_W], sec_step[btcr_pkg::TMO_W]); // R3
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st <= btcr_reset_state(); // R1 R2 R6 R7 R9
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;
  assign pri_timeout = st.pri_tmo;
  assign sec_timeout = st.sec_tmo;

endmodule : btcr_regs

// ==== btcr_checker.sv ====
// port assertions of the bridge timeout and capability register bank
module btcr_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire btcr_pkg::btcr_req_t avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire btcr_pkg::btcr_wait_t dly_wait,
  input wire logic mode_strap_low,
  input wire logic mode_strap_high,
  input wire logic pri_timeout,
  input wire logic sec_timeout
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic tk = (avs_req.read || avs_req.write) && avs_waitrequest;
  wire logic rd = avs_req.read && !avs_req.write && avs_waitrequest;
  property p_tk_ans; tk |=> !avs_waitrequest; endproperty
  a_tk_ans: assert property (p_tk_ans) else $error("request not answered");
  property p_ans_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ans_one: assert property (p_ans_one) else $error("answer longer than one cycle");
  property p_pri_one; pri_timeout |=> !pri_timeout; endproperty
  a_pri_one: assert property (p_pri_one) else $error("primary timeout not a pulse");
  property p_sec_cause; sec_timeout |-> $past(dly_wait.sec_wait, 1); endproperty
  a_sec_cause: assert property (p_sec_cause) else $error("secondary timeout without wait");
  property p_pri_cause; pri_timeout |-> $past(dly_wait.pri_wait, 1); endproperty
  a_pri_cause: assert property (p_pri_cause) else $error("primary timeout without wait");
  property p_pm; rd && avs_req.address == 8'hDC |=> avs_readdata == 32'h00010B01; endproperty
  a_pm: assert property (p_pm) else $error("power dword wrong");
  property p_slot; rd && avs_req.address == 8'hB0 |=> avs_readdata[7:0] == 8'h04; endproperty
  a_slot: assert property (p_slot) else $error("slot identifier wrong");
  property p_next; rd && avs_req.address == 8'hB0 && (mode_strap_low || mode_strap_high)
    |=> avs_readdata[15:8] == 8'h00; endproperty
  a_next: assert property (p_next) else $error("slot next link wrong");
  property p_rsv; rd && avs_req.address == 8'hB0 |=> avs_readdata[23:22] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("slot reserved bits set");
endmodule : btcr_checker

bind btcr_regs btcr_checker u_chk (.sys_clk(sys_clk), .reset(reset), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dly_wait(dly_wait),
  .mode_strap_low(mode_strap_low), .mode_strap_high(mode_strap_high),
  .pri_timeout(pri_timeout), .sec_timeout(sec_timeout));

// ==== btcr_host.sv ====
// configuration host model: one avalon-mm access per go
module btcr_host (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic go_wr,
  input wire logic [7:0] go_addr,
  input wire logic [31:0] go_data,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output btcr_pkg::btcr_req_t avs_req = '0,
  output logic [31:0] rdata = '0,
  output logic busy = 1'b0
);
  // request held until waitrequest is sampled low
  always @(posedge sys_clk) begin
    if (busy && !avs_waitrequest) begin
      avs_req <= '0;
      rdata <= avs_readdata;
      busy <= 1'b0;
    end else if (go && !busy) begin
      avs_req <= '{read: !go_wr, write: go_wr, address: go_addr, writedata: go_data, byteenable: 4'hF};
      busy <= 1'b1;
    end
  end
endmodule : btcr_host

// ==== bridge_timeout_and_capability_regs_tb.sv ====
// testbench of the bridge timeout and capability register bank
module bridge_timeout_and_capability_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  btcr_pkg::btcr_req_t avs_req;
  btcr_pkg::btcr_wait_t dly_wait = '0;
  logic [31:0] avs_readdata, rdata, go_data = '0;
  logic avs_waitrequest, pri_timeout, sec_timeout, busy, go = 1'b0, go_wr = 1'b0;
  logic [7:0] go_addr = '0;
  logic strap_lo = 1'b1;
  logic strap_hi = 1'b0;
  int fails = 0;
  int tests_run = 0;
  btcr_regs dut (.sys_clk(sys_clk), .reset(reset), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dly_wait(dly_wait), .mode_strap_low(strap_lo), .mode_strap_high(strap_hi),
    .pri_timeout(pri_timeout), .sec_timeout(sec_timeout));
  btcr_host host (.sys_clk(sys_clk), .go(go), .go_wr(go_wr), .go_addr(go_addr), .go_data(go_data),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .avs_req(avs_req), .rdata(rdata), .busy(busy));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic close_out;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // entered just after a rising edge; returns just after the edge following the one that ends the access
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    go <= 1'b1;
    go_wr <= wr;
    go_addr <= a;
    go_data <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    do @(posedge sys_clk); while (busy);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  task automatic t_reset;
    rd(8'h80, 32'h80008000);
    rd(8'hB0, 32'h00000004);
    rd(8'hDC, 32'h00010B01);
    rd(8'h40, 32'h00000000);
    $display("reset values done");
  endtask : t_reset
  task automatic t_write;
    acc(1'b1, 8'h80, 32'h00030002);
    rd(8'h80, 32'h00030002);
    acc(1'b1, 8'hB0, 32'hFFFFFFFF);
    rd(8'hB0, 32'hFF3F0004);
    acc(1'b1, 8'hDC, 32'hFFFFFFFF);
    rd(8'hDC, 32'h00010B01);
    acc(1'b1, 8'hB0, 32'h12230000);
    rd(8'hB0, 32'h12230004);
    $display("register writes done");
  endtask : t_write
  task automatic t_timeout;
    int pri_at = 0;
    int sec_at = 0;
    dly_wait <= '{pri_wait: 1'b1, sec_wait: 1'b1};
    for (int i = 1; i <= 7; i++) begin
      @(negedge sys_clk);
      if (pri_timeout === 1'b1) pri_at = i;
      if (sec_timeout === 1'b1) sec_at = i;
      @(posedge sys_clk);
    end
    dly_wait <= '0;
    chk(32'(pri_at), 32'h00000003);
    chk(32'(sec_at), 32'h00000004);
    rd(8'hF0, 32'h00000003);
    acc(1'b1, 8'hF0, 32'h00000003);
    rd(8'hF0, 32'h00000000);
    $display("master timeouts done");
  endtask : t_timeout
  // mid-run reset with new strap levels; straps are caught at the first edge after release
  task automatic t_straps(input logic lo, input logic hi, input logic [7:0] nxt);
    reset <= 1'b1;
    strap_lo <= lo;
    strap_hi <= hi;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd(8'h80, 32'h80008000);
    rd(8'hB0, {16'h0000, nxt, 8'h04});
    $display("strap case done");
  endtask : t_straps
  // reset limit: pulse seen half a cycle after the 8000h-th counting edge
  task automatic t_long;
    int n = 0;
    dly_wait <= '{pri_wait: 1'b1, sec_wait: 1'b0};
    do begin
      @(negedge sys_clk);
      n++;
    end while (pri_timeout !== 1'b1);
    @(posedge sys_clk);
    dly_wait <= '0;
    chk(32'(n), 32'h00008001);
    $display("reset limit done");
  endtask : t_long
  initial begin
    repeat (40000) @(posedge sys_clk);
    fails++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_write();
    t_timeout();
    t_straps(1'b0, 1'b1, 8'h00);
    t_straps(1'b0, 1'b0, 8'hDC);
    t_long();
    close_out();
  end
endmodule : bridge_timeout_and_capability_regs_tb
